// File: common/cal_pkg.sv
// Package with register map, field layout, reset values and timing for the calendar value registers.
package cal_pkg;

  // ****************************************
  // Register byte addresses on the APB.
  // ****************************************
  localparam logic [7:0] ADDR_CUR_HM = 8'h00;     // Current hours and minutes.
  localparam logic [7:0] ADDR_CUR_DW = 8'h04;     // Current day and weekday.
  localparam logic [7:0] ADDR_CUR_YM = 8'h08;     // Current year and month.
  localparam logic [7:0] ADDR_ALM_SEC = 8'h0c;    // Alarm seconds.
  localparam logic [7:0] ADDR_ALM_HM = 8'h10;     // Alarm hours and minutes.
  localparam logic [7:0] ADDR_ALM_DW = 8'h14;     // Alarm day and weekday.
  localparam logic [7:0] ADDR_ALM_YM = 8'h18;     // Alarm year and month.
  localparam logic [7:0] ADDR_CAP_SEC = 8'h1c;    // Capture seconds.
  localparam logic [7:0] ADDR_CTRL = 8'h20;       // Control: alarm enable, capture enable.
  localparam logic [7:0] ADDR_STAT = 8'h24;       // Status: capture flag, sync flag.
  localparam logic [7:0] ADDR_CUR_SEC = 8'h28;    // Current seconds, needed for the capture.

  // ****************************************
  // Writable bit masks of each register.
  // ****************************************
  localparam logic [15:0] MASK_HM = 16'h3f7f;     // Hours 13:8, minutes 6:0.
  localparam logic [15:0] MASK_DW = 16'h3f07;     // Day 13:8, weekday 2:0.
  localparam logic [15:0] MASK_YM = 16'hff1f;     // Year 15:8, month 4:0.
  localparam logic [15:0] MASK_SEC = 16'h7f00;    // Seconds 14:8.
  localparam logic [15:0] MASK_POR_CUR_HM = 16'h2060; // Current bits that clear at power-on.
  localparam logic [15:0] MASK_POR_CUR_DW = 16'h3f00;
  localparam logic [15:0] MASK_POR_CUR_YM = 16'hf000;

  // ****************************************
  // Control and status bit positions.
  // ****************************************
  localparam int CTRL_ALARM_EN_BIT = 0;
  localparam int CTRL_CAP_EN_BIT = 1;
  localparam int STAT_CAP_FLAG_BIT = 3;
  localparam int STAT_SYNC_BIT = 2;

  // ****************************************
  // Timing.
  // ****************************************
  localparam int CLK_MHZ = 250;                   // Clock rate in MHz.
  localparam int TICK_US = 1000000;               // One second, in microseconds.
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US; // Cycles per second.
  localparam int SYNC_LEAD = 8;                   // Cycles of sync warning ahead of a tick.

  // Packed calendar word set, carried as one group.
  typedef struct packed {
    logic [15:0] sec;
    logic [15:0] hm;
    logic [15:0] dw;
    logic [15:0] ym;
  } cal_words_t;

  // APB request as seen by the slave.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// File: logic/bcd_digit.sv
// One BCD digit counter with a settable top value and carry out.
`timescale 1ns/100ps
module bcd_digit
  import cal_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] top,
  input wire logic inc,
  output logic [W-1:0] next,
  output logic carry
);

  // ****************************************
  // Digit step.
  // ****************************************

  // Wraps to zero past the top value and reports the carry.
  always_comb begin
    carry = inc && (value >= top);
    if (!inc) begin
      next = value;
    end else if (carry) begin
      next = '0;
    end else begin
      next = W'(value + 1'b1);
    end
  end

endmodule

// File: logic/cal_regs.sv
// Calendar value registers with APB slave, BCD time keeping and a capture of the seconds.
//
// Summary of operation
// - Hours in two BCD digits, bits 13:8.
// - Minutes in two BCD digits, bits 6:0.
// - Alarm and capture seconds in bits 14:8.
// - Day of month in BCD, bits 13:8.
// - Weekday is three bits, values zero to six.
// - Month tens bit 4, units bits 3:0.
// - Year tens 15:12, units 11:8.
// - Undefined bits ignore writes, read zero.
// - Capture words persist over warm reset when disabled.
// - Power-on clears alarm, capture and upper tens.
// - Writing one to flag starts a capture.
// - Sync bit high when time may change.
`timescale 1ns/100ps
module cal_regs
  import cal_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic warm_resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sync_flag
);

  // ****************************************
  // State.
  // ****************************************

  // All state of the module in one record.
  typedef struct packed {
    cal_words_t cur;        // Current time and date words.
    cal_words_t alm;        // Alarm values.
    logic [15:0] cap_sec;   // Captured seconds.
    logic alarm_en;         // Alarm enable.
    logic cap_en;           // Capture enable.
    logic cap_flag;         // Capture event flag.
    logic cap_req;          // Capture requested, done at the next cycle.
    logic sync;             // Time may change soon.
    logic [31:0] tick_cnt;  // Cycles since the last second.
    logic [31:0] rdata;     // Read data register.
    logic ready;            // Answer of the access phase.
    logic err;              // Error answer.
    logic wrst_s1;          // Warm reset synchroniser stage one.
    logic wrst_s2;          // Warm reset synchroniser stage two.
  } state_t;

  state_t s_r;       // Registered state.
  state_t s_nxt;     // Next state.
  apb_req_t req;     // Grouped APB request.

  // Next values of the digits, seconds up to years.
  logic [3:0] su_n; // Seconds units.
  logic [2:0] st_n; // Seconds tens.
  logic [3:0] mu_n; // Minutes units.
  logic [2:0] mt_n; // Minutes tens.
  logic [3:0] hu_n; // Hours units.
  logic [1:0] ht_n; // Hours tens.
  logic [2:0] wd_n; // Weekday.
  logic [3:0] du_n; // Day units.
  logic [1:0] dt_n; // Day tens.
  logic [3:0] ou_n; // Month units.
  logic ou_t_n; // Month tens.
  logic [3:0] yu_n; // Year units.
  logic [3:0] yt_n; // Year tens.
  // Carries between digits; of the tens digits only seconds and minutes use one, other wraps are decided from the tens value.
  logic c_su; // Seconds units pass nine.
  logic c_st; // Seconds pass 59.
  logic c_mu; // Minutes units pass nine.
  logic c_mt; // Minutes pass 59.
  logic c_hu; // Hours units reach their top.
  logic c_du; // Day units reach their top.
  logic c_ou; // Month units reach their top.
  logic c_yu; // Year units pass nine.
  logic tick;         // One second has elapsed.
  logic hr_wrap;      // Hours pass 23.
  logic day_wrap;     // Day passes 31.
  logic mon_wrap;     // Month passes 12.
  logic [3:0] hu_top; // Units limit for hours.
  logic [3:0] du_top; // Units limit for days.
  logic [3:0] ou_top; // Units limit for months.

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign tick = (s_r.tick_cnt == 32'(TICK - 1));

  // ****************************************
  // Digit limits.
  // ****************************************

  // The units limit depends on the tens digit so that 23, 31 and 12 are the tops.
  always_comb begin
    hu_top = (s_r.cur.hm[13:12] == 2'h2) ? 4'h3 : 4'h9;
    du_top = (s_r.cur.dw[13:12] == 2'h3) ? 4'h1 : 4'h9;
    ou_top = s_r.cur.ym[4] ? 4'h2 : 4'h9;
  end

  // ****************************************
  // Digit chain.
  // ****************************************

  // Seconds, minutes, hours: the carry ripples through each digit.
  bcd_digit #(.W(4)) u_su (
    .value(s_r.cur.sec[11:8]),
    .top(4'h9),
    .inc(tick),
    .next(su_n),
    .carry(c_su)
  );
  bcd_digit #(.W(3)) u_st (
    .value(s_r.cur.sec[14:12]),
    .top(3'h5),
    .inc(c_su),
    .next(st_n),
    .carry(c_st)
  );
  bcd_digit #(.W(4)) u_mu (
    .value(s_r.cur.hm[3:0]),
    .top(4'h9),
    .inc(c_st),
    .next(mu_n),
    .carry(c_mu)
  );
  bcd_digit #(.W(3)) u_mt (
    .value(s_r.cur.hm[6:4]),
    .top(3'h5),
    .inc(c_mu),
    .next(mt_n),
    .carry(c_mt)
  );
  bcd_digit #(.W(4)) u_hu (
    .value(s_r.cur.hm[11:8]),
    .top(hu_top),
    .inc(c_mt),
    .next(hu_n),
    .carry(c_hu)
  );
  bcd_digit #(.W(2)) u_ht (
    .value(s_r.cur.hm[13:12]),
    .top(2'h2),
    .inc(c_hu),
    .next(ht_n),
    .carry()
  );
  assign hr_wrap = c_hu && (s_r.cur.hm[13:12] == 2'h2);

  // Weekday steps once a day and wraps after six.
  bcd_digit #(.W(3)) u_wd (
    .value(s_r.cur.dw[2:0]),
    .top(3'h6),
    .inc(hr_wrap),
    .next(wd_n),
    .carry()
  );

  // Day of month from 01 to 31; the month length is not checked.
  bcd_digit #(.W(4)) u_du (
    .value(s_r.cur.dw[11:8]),
    .top(du_top),
    .inc(hr_wrap),
    .next(du_n),
    .carry(c_du)
  );
  bcd_digit #(.W(2)) u_dt (
    .value(s_r.cur.dw[13:12]),
    .top(2'h3),
    .inc(c_du),
    .next(dt_n),
    .carry()
  );
  assign day_wrap = c_du && (s_r.cur.dw[13:12] == 2'h3);

  // Month from 01 to 12.
  bcd_digit #(.W(4)) u_ou (
    .value(s_r.cur.ym[3:0]),
    .top(ou_top),
    .inc(day_wrap),
    .next(ou_n),
    .carry(c_ou)
  );
  bcd_digit #(.W(1)) u_ot (
    .value(s_r.cur.ym[4]),
    .top(1'b1),
    .inc(c_ou),
    .next(ou_t_n),
    .carry()
  );
  assign mon_wrap = c_ou && s_r.cur.ym[4];

  // Year from 00 to 99.
  bcd_digit #(.W(4)) u_yu (
    .value(s_r.cur.ym[11:8]),
    .top(4'h9),
    .inc(mon_wrap),
    .next(yu_n),
    .carry(c_yu)
  );
  bcd_digit #(.W(4)) u_yt (
    .value(s_r.cur.ym[15:12]),
    .top(4'h9),
    .inc(c_yu),
    .next(yt_n),
    .carry()
  );

  // ****************************************
  // Next state.
  // ****************************************

  // Counting, bus writes, capture and read data in one pass.
  always_comb begin
    logic wr;
    logic rd;
    logic hit;
    logic [15:0] wd;
    wr = 1'b0;
    rd = 1'b0;
    hit = 1'b0;
    wd = 16'h0000;
    s_nxt = s_r;

    // Warm reset goes through two flip-flops before use.
    s_nxt.wrst_s1 = warm_resetn;
    s_nxt.wrst_s2 = s_r.wrst_s1;

    // Second prescaler.
    s_nxt.tick_cnt = tick ? 32'h0000_0000 : 32'(s_r.tick_cnt + 1);

    // Sync warns during the last cycles before a tick, the tick itself and the cycle after it.
    s_nxt.sync = (s_r.tick_cnt >= 32'(TICK - 1 - SYNC_LEAD));

    // Carry ripple for the current words; day and month wrap to 01, not to zero.
    if (tick) begin
      s_nxt.cur.sec = {1'b0, st_n, su_n, 8'h00};
      s_nxt.cur.hm = {2'b00, (hr_wrap ? 2'h0 : ht_n), (hr_wrap ? 4'h0 : hu_n), 1'b0, mt_n, mu_n};
      s_nxt.cur.dw = {2'b00, (day_wrap ? 2'h0 : dt_n), (day_wrap ? 4'h1 : du_n), 5'h00, wd_n};
      s_nxt.cur.ym = {yt_n, yu_n, 3'h0, (mon_wrap ? 1'b0 : ou_t_n), (mon_wrap ? 4'h1 : ou_n)};
    end

    // Capture request from the previous cycle copies the seconds.
    if (s_r.cap_req) begin
      s_nxt.cap_sec = s_r.cur.sec & MASK_SEC;
      s_nxt.cap_flag = 1'b1;
      s_nxt.cap_req = 1'b0;
    end

    // One-cycle answer: ready rises the cycle after the first access cycle and falls after.
    s_nxt.ready = psel && penable && !s_r.ready;
    s_nxt.err = 1'b0;
    wr = req.psel && req.penable && req.pwrite && !s_r.ready;
    rd = req.psel && req.penable && !req.pwrite && !s_r.ready;
    wd = req.pwdata[15:0];

    // Write decode; masks drop undefined bits.
    if (wr) begin
      hit = 1'b1;
      case (req.paddr)
        ADDR_CUR_HM: s_nxt.cur.hm = wd & MASK_HM;
        ADDR_CUR_DW: s_nxt.cur.dw = wd & MASK_DW;
        ADDR_CUR_YM: s_nxt.cur.ym = wd & MASK_YM;
        ADDR_CUR_SEC: begin
          s_nxt.cur.sec = wd & MASK_SEC;
          s_nxt.tick_cnt = 32'h0000_0000;
        end
        // Alarm writes are taken regardless; software keeps them to alarm-off times.
        ADDR_ALM_SEC: s_nxt.alm.sec = wd & MASK_SEC;
        ADDR_ALM_HM: s_nxt.alm.hm = wd & MASK_HM;
        ADDR_ALM_DW: s_nxt.alm.dw = wd & MASK_DW;
        ADDR_ALM_YM: s_nxt.alm.ym = wd & MASK_YM;
        ADDR_CAP_SEC: s_nxt.cap_sec = wd & MASK_SEC;
        ADDR_CTRL: begin
          s_nxt.alarm_en = wd[CTRL_ALARM_EN_BIT];
          s_nxt.cap_en = wd[CTRL_CAP_EN_BIT];
        end
        ADDR_STAT: begin
          // Writing one requests a capture; writing zero clears the flag unless a capture lands now.
          if (wd[STAT_CAP_FLAG_BIT]) begin
            s_nxt.cap_req = 1'b1;
          end else if (!s_r.cap_req) begin
            s_nxt.cap_flag = 1'b0;
          end
        end
        default: hit = 1'b0;
      endcase
      s_nxt.err = !hit;
    end

    // Read decode from the current state.
    if (rd) begin
      hit = 1'b1;
      case (req.paddr)
        ADDR_CUR_HM: s_nxt.rdata = {16'h0000, s_r.cur.hm};
        ADDR_CUR_DW: s_nxt.rdata = {16'h0000, s_r.cur.dw};
        ADDR_CUR_YM: s_nxt.rdata = {16'h0000, s_r.cur.ym};
        ADDR_CUR_SEC: s_nxt.rdata = {16'h0000, s_r.cur.sec};
        ADDR_ALM_SEC: s_nxt.rdata = {16'h0000, s_r.alm.sec};
        ADDR_ALM_HM: s_nxt.rdata = {16'h0000, s_r.alm.hm};
        ADDR_ALM_DW: s_nxt.rdata = {16'h0000, s_r.alm.dw};
        ADDR_ALM_YM: s_nxt.rdata = {16'h0000, s_r.alm.ym};
        ADDR_CAP_SEC: s_nxt.rdata = {16'h0000, s_r.cap_sec};
        ADDR_CTRL: s_nxt.rdata = {30'h0000_0000, s_r.cap_en, s_r.alarm_en};
        ADDR_STAT: s_nxt.rdata = {28'h000_0000, s_r.cap_flag, s_r.sync, 2'b00};
        default: begin
          hit = 1'b0;
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
      s_nxt.err = !hit;
    end

    // Warm reset clears control, but a disabled capture keeps its stored word.
    if (!s_r.wrst_s2) begin
      s_nxt.alarm_en = 1'b0;
      s_nxt.cap_en = 1'b0;
      s_nxt.cap_req = 1'b0;
      s_nxt.alm = '0;
      if (s_r.cap_en) begin
        s_nxt.cap_sec = 16'h0000;
        s_nxt.cap_flag = 1'b0;
      end
    end
  end

  // ****************************************
  // Registers.
  // ****************************************

  // Power-on reset. The current digits outside the cleared bits have no defined reset; they start at zero
  // here only because an asynchronous flop needs a constant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs.
  // ****************************************

  // All straight from flip-flops.
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign sync_flag = s_r.sync;

endmodule

// File: test/cal_regs_chk.sv
// Checker for the calendar value registers, bound to cal_regs.
`timescale 1ns/100ps
module cal_regs_chk
  import cal_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic warm_resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sync_flag
);
  // ****
  // Helpers
  // ****
  logic rd; // A read is answered in this cycle.
  logic mapped; // The address hits a register; the map is dense up to current seconds.
  assign rd = pready && psel && !pwrite;
  assign mapped = (paddr <= ADDR_CUR_SEC) && (paddr[1:0] == 2'b00);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // First access cycle, not yet answered.
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  // Warning stays up for eight more cycles.
  sequence s_warn;
    sync_flag [*8];
  endsequence
  // ****
  // Properties
  // ****
  AST_ACC: assert property (s_acc |=> pready) else $error("answer not one cycle after access");
  AST_ONE: assert property (pready |=> !pready) else $error("ready held too long");
  AST_ERR: assert property (pready |-> pslverr == !mapped) else $error("error flag wrong");
  AST_HI: assert property (rd |-> prdata[31:16] == 16'h0000) else $error("upper half not zero");
  AST_HM: assert property (rd && paddr == ADDR_CUR_HM |->
    (prdata[15:0] & ~MASK_HM) == 16'h0000 && prdata[13:12] <= 2'd2 && prdata[11:8] <= 4'd9
    && prdata[6:4] <= 3'd5 && prdata[3:0] <= 4'd9) else $error("hours or minutes out of range");
  AST_DW: assert property (rd && paddr == ADDR_CUR_DW |->
    (prdata[15:0] & ~MASK_DW) == 16'h0000 && prdata[11:8] <= 4'd9 && prdata[2:0] <= 3'd6)
    else $error("day or weekday out of range");
  AST_YM: assert property (rd && paddr == ADDR_CUR_YM |->
    (prdata[15:0] & ~MASK_YM) == 16'h0000 && prdata[15:12] <= 4'd9 && prdata[11:8] <= 4'd9
    && prdata[3:0] <= 4'd9) else $error("year or month out of range");
  AST_SEC: assert property (rd && (paddr == ADDR_ALM_SEC || paddr == ADDR_CAP_SEC) |->
    (prdata[15:0] & ~MASK_SEC) == 16'h0000) else $error("seconds word has stray bits");
  AST_SYNC: assert property ($rose(sync_flag) |=> s_warn ##1 !sync_flag)
    else $error("sync warning width wrong");
endmodule
bind cal_regs cal_regs_chk #(.TICK(TICK)) u_chk (.pclk(pclk), .presetn(presetn),
  .warm_resetn(warm_resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_flag(sync_flag));

// File: test/cal_regs_tb.sv
// Self-checking testbench for the calendar value registers.
`timescale 1ns/100ps
module cal_regs_tb
  import cal_pkg::*;
;
  logic pclk, presetn, warm_resetn, psel, penable, pwrite, pready, pslverr, sync_flag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] q; // Last read data.
  logic e; // Last error flag.
  int n_mismatch, compares;
  // Alarm and capture words with their writable masks.
  logic [7:0] alm [5] = '{ADDR_ALM_SEC, ADDR_ALM_HM, ADDR_ALM_DW, ADDR_ALM_YM, ADDR_CAP_SEC};
  logic [15:0] msk [5] = '{MASK_SEC, MASK_HM, MASK_DW, MASK_YM, MASK_SEC};
  // A short second keeps the carry test brief.
  cal_regs #(.TICK(20)) u_dut (.pclk(pclk), .presetn(presetn), .warm_resetn(warm_resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_flag(sync_flag));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle cycle follows so no signal is driven twice at one edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata[15:0];
    e = pslverr;
    if (n >= 40) chk(16'hffff, 16'h0000);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(q, exp);
  endtask
  // Waits until a warning window closes, so the next tick is far away.
  task automatic sync_end();
    int n;
    n = 0;
    while (sync_flag !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    while (sync_flag !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60) chk(16'hffff, 16'h0000);
  endtask
  task automatic warm();
    warm_resetn <= 1'b0;
    repeat (4) @(posedge pclk);
    warm_resetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    foreach (alm[i]) rdchk(alm[i], 16'h0000);
    apb(1'b0, ADDR_CUR_HM, 16'h0000);
    chk(q & MASK_POR_CUR_HM, 16'h0000);
    apb(1'b0, ADDR_CUR_YM, 16'h0000);
    chk(q & MASK_POR_CUR_YM, 16'h0000);
    apb(1'b0, ADDR_CUR_DW, 16'h0000);
    chk(q & MASK_POR_CUR_DW, 16'h0000);
  endtask
  // All-ones writes keep only the digit fields; an unmapped word is refused.
  task automatic t_bits();
    apb(1'b1, ADDR_CTRL, 16'h0000);
    foreach (alm[i]) begin
      apb(1'b1, alm[i], 16'hffff);
      rdchk(alm[i], msk[i]);
    end
    apb(1'b1, 8'h2c, 16'hffff);
    chk({15'h0000, e}, 16'h0001);
    rdchk(8'h2c, 16'h0000);
    apb(1'b1, ADDR_CTRL, 16'h0001);
    rdchk(ADDR_CTRL, 16'h0001);
    apb(1'b1, ADDR_CTRL, 16'h0000);
  endtask
  // The status copy of the sync flag reads high inside a warning window.
  task automatic t_sync();
    int n;
    n = 0;
    sync_end();
    while (sync_flag !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b0, ADDR_STAT, 16'h0000);
    chk(q & 16'h0004, 16'h0004);
  endtask
  // Last second of a year rolls every field over.
  task automatic t_carry();
    sync_end();
    apb(1'b1, ADDR_CUR_SEC, 16'h5900);
    apb(1'b1, ADDR_CUR_HM, 16'h2359);
    apb(1'b1, ADDR_CUR_DW, 16'h3106);
    apb(1'b1, ADDR_CUR_YM, 16'h9912);
    sync_end();
    rdchk(ADDR_CUR_HM, 16'h0000);
    rdchk(ADDR_CUR_DW, 16'h0100);
    rdchk(ADDR_CUR_YM, 16'h0001);
  endtask
  // Capture, then warm resets with capture off and on.
  task automatic t_cap();
    sync_end();
    apb(1'b1, ADDR_CUR_SEC, 16'h4700);
    apb(1'b1, ADDR_STAT, 16'h0008);
    apb(1'b0, ADDR_STAT, 16'h0000);
    chk(q & 16'h000c, 16'h0008);
    rdchk(ADDR_CAP_SEC, 16'h4700);
    apb(1'b1, ADDR_CTRL, 16'h0000);
    warm();
    rdchk(ADDR_CAP_SEC, 16'h4700);
    rdchk(ADDR_ALM_HM, 16'h0000);
    apb(1'b1, ADDR_CTRL, 16'h0002);
    warm();
    rdchk(ADDR_CAP_SEC, 16'h0000);
  endtask
  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    warm_resetn = 1'b1;
    n_mismatch = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_bits();
    t_sync();
    t_carry();
    t_cap();
    close_out();
  end
  // The run needs a few hundred cycles; this bound is far beyond it.
  initial begin
    #200us;
    n_mismatch++;
    close_out();
  end
endmodule
